// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
    import ubt_pkg::*;
    logic        clk, arst_n, ce, avs_read, avs_write, avs_waitrequest;
    logic        bus_stall_n, mux_bus_line_six, rxd, txd, irq_tx, irq_rx;
    logic        cpu_idle, fetch_start, mem_we, boot_mode;
    logic [3:0]  avs_address;
    logic [7:0]  baud_div, mem_wdata;
    logic [23:0] mem_addr;
    logic [31:0] avs_writedata, avs_readdata, d, n_st, n_fetch;
    logic [15:0] dma_mcr, dma_tdr, dma_cnt;
    logic [10:0] f;
    int          n_mismatch, samples_checked;

    ubt_uart #(.DIV_W(8)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .bus_stall_n(bus_stall_n), .mux_bus_line_six(mux_bus_line_six),
        .baud_div(baud_div), .rxd(rxd), .txd(txd), .irq_tx(irq_tx), .irq_rx(irq_rx),
        .cpu_idle(cpu_idle), .fetch_start(fetch_start), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .boot_mode(boot_mode),
        .dma_mcr(dma_mcr), .dma_tdr(dma_tdr), .dma_cnt(dma_cnt)
    );
    ubt_sender #(.BITC(16)) snd (.clk(clk), .arst_n(arst_n), .rxd(rxd));

    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        avs_address <= a;
        avs_writedata <= {24'h000000, v};
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rst(input logic boot);
        arst_n <= 1'b0;
        bus_stall_n <= ~boot;
        mux_bus_line_six <= boot;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        bus_stall_n <= 1'b1;
        mux_bus_line_six <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wirq();
        int n;
        n = 0;
        while (irq_rx !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(irq_rx, 1'b1);
    endtask

    // sample one transmitted frame at bit centres
    task automatic cap(output logic [10:0] fr);
        while (txd !== 1'b0) @(posedge clk);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            fr[i] = txd;
            repeat (16) @(posedge clk);
        end
    endtask

    // boot byte store monitor
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            chk(mem_addr, n_st);
            chk(mem_wdata, n_st[7:0] ^ 8'h3c);
            n_st++;
        end
        if (fetch_start === 1'b1) n_fetch++;
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial begin
        {arst_n, ce, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {bus_stall_n, mux_bus_line_six, baud_div, n_st, n_fetch} = '0;
        n_mismatch = 0;
        samples_checked = 0;
        ce = 1'b1;
        bus_stall_n = 1'b1;
        rst(1'b0);
        rc(ADDR_CFG, 32'h00);
        rc(ADDR_TXCS, 32'h01);
        rc(ADDR_RXCS, 32'h00);
        rc(ADDR_BOOT, 32'h01);
        rc(4'hf, 32'h00);
        chk(boot_mode, 1'b0);
        wr(ADDR_CFG, 8'hf0);
        wr(ADDR_RXCS, 8'hc0);
        snd.send(8'ha5, 1'b1, 1'b1, 1'b0, 1'b0);
        wirq();
        rc(ADDR_RXCS, 32'hc1);
        rc(ADDR_RXDATA, 32'ha5);
        rc(ADDR_RXCS, 32'hc0);
        chk(irq_rx, 1'b0);
        snd.send(8'h3c, 1'b1, 1'b1, 1'b1, 1'b0);
        wirq();
        rc(ADDR_RXCS, 32'hd5);
        rc(ADDR_RXDATA, 32'h3c);
        snd.send(8'h0f, 1'b1, 1'b1, 1'b0, 1'b0);
        wirq();
        rc(ADDR_RXCS, 32'hd5);
        rc(ADDR_RXDATA, 32'h0f);
        wr(ADDR_RXCS, 8'hc0);
        rc(ADDR_RXCS, 32'hc0);
        wr(ADDR_RXCS, 8'h00);
        wr(ADDR_CFG, 8'he0);
        wr(ADDR_RXCS, 8'hc0);
        snd.send(8'ha5, 1'b1, 1'b0, 1'b0, 1'b0);
        wirq();
        rc(ADDR_RXCS, 32'hc1);
        rc(ADDR_RXDATA, 32'ha5);
        snd.send(8'h11, 1'b1, 1'b0, 1'b0, 1'b0);
        snd.send(8'h22, 1'b1, 1'b0, 1'b0, 1'b0);
        wirq();
        rc(ADDR_RXCS, 32'hd3);
        rc(ADDR_RXDATA, 32'h22);
        wr(ADDR_RXCS, 8'hc0);
        snd.send(8'h33, 1'b1, 1'b0, 1'b0, 1'b1);
        wirq();
        rc(ADDR_RXCS, 32'hd9);
        rc(ADDR_RXDATA, 32'h33);
        snd.send(8'h44, 1'b1, 1'b0, 1'b0, 1'b0);
        wirq();
        rc(ADDR_RXCS, 32'hc1);
        rc(ADDR_RXDATA, 32'h44);
        wr(ADDR_TXCS, 8'hc0);
        chk(irq_tx, 1'b1);
        rc(ADDR_TXCS, 32'hc1);
        wr(ADDR_TXDATA, 8'h5a);
        cap(f);
        chk(f, {1'b1, ~(^8'h5a), 8'h5a, 1'b0});
        chk(irq_tx, 1'b1);
        wr(ADDR_TXCS, 8'hc4);
        wr(ADDR_TXDATA, 8'hff);
        cap(f);
        chk(f, 11'h000);
        chk(txd, 1'b1);
        wr(ADDR_TXCS, 8'h88);
        repeat (4) begin
            repeat (50) @(posedge clk);
            chk(txd, 1'b0);
        end
        wr(ADDR_TXCS, 8'h80);
        repeat (10) @(posedge clk);
        chk(txd, 1'b1);
        rst(1'b1);
        rc(ADDR_CFG, 32'he2);
        rc(ADDR_RXCS, 32'h80);
        chk({boot_mode, cpu_idle}, 2'b11);
        chk(dma_cnt, DMA_CNT_BOOT);
        chk({dma_mcr, dma_tdr}, {DMA_MCR_BOOT, DMA_TDR_BOOT});
        n_st = 0;
        for (int i = 0; i < 256; i++) snd.send(i[7:0] ^ 8'h3c, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (100) @(posedge clk);
        chk(n_st, 32'd256);
        chk(n_fetch, 32'd1);
        chk(cpu_idle, 1'b0);
        rc(ADDR_BOOT, 32'h04);
        rc(ADDR_RXCS, 32'h80);
        rst(1'b1);
        snd.send(8'h55, 1'b1, 1'b0, 1'b0, 1'b1);
        repeat (40) @(posedge clk);
        chk(txd, 1'b0);
        rd(ADDR_RXCS, d);
        chk(d[RX_FE], 1'b1);
        repeat (200) @(posedge clk);
        chk(txd, 1'b0);
        conclude();
    end
endmodule

// *** dv/ubt_sender.sv ***
`timescale 1ns/10ps
module ubt_sender #(
    parameter int BITC = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic     rxd
);
    int since;
    // clocks elapsed since reset release, saturating at 15
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) since <= 0;
        else if (since < 15) since <= since + 1;
    end
    initial rxd = 1'b1;
    // one character: start, data lsb first, optional parity, one stop
    task automatic send(input logic [7:0] d, input logic pe, input logic ev,
                        input logic bp, input logic bs);
        logic [10:0] fr;
        int          n;
        fr = {~bs, (ev ? ^d : ~^d) ^ bp, d, 1'b0};
        if (!pe) fr[9] = ~bs;
        n = pe ? 11 : 10;
        @(posedge clk);
        while (since < 15) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= fr[i];
            repeat (BITC) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BITC) @(posedge clk);
    endtask
endmodule

// *** dv/ubt_uart_properties.sv ***
`timescale 1ns/10ps
module ubt_uart_chk
    import ubt_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cpu_idle,
    input wire logic        fetch_start,
    input wire logic        mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic        boot_mode,
    input wire logic [15:0] dma_mcr,
    input wire logic [15:0] dma_tdr,
    input wire logic [15:0] dma_cnt
);
    logic        seen_ff;
    logic [23:0] last_ff;
    // remember the previous store address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_ff <= 1'b0;
            last_ff <= 24'h000000;
        end else if (mem_we) begin
            seen_ff <= 1'b1;
            last_ff <= mem_addr;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // bus request phases
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd_acc;
        avs_read && !avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_req |=> !avs_waitrequest)
        else $error("bus request not answered in the next cycle");
    a_read_upper: assert property (s_rd_acc |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    a_unmapped_zero: assert property (s_rd_acc ##0 (avs_address > ADDR_BOOT) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_dma_boot: assert property (boot_mode |-> dma_mcr == DMA_MCR_BOOT && dma_tdr == DMA_TDR_BOOT)
        else $error("boot dma presets wrong");
    a_dma_plain: assert property (!boot_mode |-> dma_mcr == 16'h0000 && dma_tdr == 16'h0000)
        else $error("dma presets present outside boot");
    a_store_idle: assert property (mem_we |-> boot_mode && cpu_idle)
        else $error("byte store outside boot loading");
    a_store_first: assert property (mem_we && !seen_ff |-> mem_addr == DMA_DST_BOOT)
        else $error("first store address not zero");
    a_store_step: assert property (mem_we && seen_ff |-> mem_addr == last_ff + 24'h000001)
        else $error("store address did not step by one");
    a_fetch_done: assert property (fetch_start |-> dma_cnt == 16'h0000 && !mem_we)
        else $error("fetch started before count exhausted");
    a_fetch_pulse: assert property (fetch_start |=> !fetch_start && !cpu_idle)
        else $error("fetch start not a pulse or core still idle");
endmodule
bind ubt_uart ubt_uart_chk u_chk (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_idle(cpu_idle), .fetch_start(fetch_start), .mem_we(mem_we), .mem_addr(mem_addr),
    .boot_mode(boot_mode), .dma_mcr(dma_mcr), .dma_tdr(dma_tdr), .dma_cnt(dma_cnt)
);

// *** shared/ubt_pkg.sv ***
package ubt_pkg;
    // register word offsets (word addresses, one register per avalon word)
    localparam logic [3:0] ADDR_CFG    = 4'h0;
    localparam logic [3:0] ADDR_TXCS   = 4'h1;
    localparam logic [3:0] ADDR_RXCS   = 4'h2;
    localparam logic [3:0] ADDR_RXDATA = 4'h3;
    localparam logic [3:0] ADDR_TXDATA = 4'h4;
    localparam logic [3:0] ADDR_BOOT   = 4'h5;
    // configuration fields
    localparam int CFG_BC_LSB = 6;
    localparam int CFG_PAR    = 5;
    localparam int CFG_EO     = 4;
    // tx control/status fields
    localparam int TX_EN  = 7;
    localparam int TX_IE  = 6;
    localparam int TX_SB  = 4;
    localparam int TX_BRK = 3;
    localparam int TX_FRC = 2;
    localparam int TX_VAL = 1;
    localparam int TX_BE  = 0;
    // rx control/status fields
    localparam int RX_EN  = 7;
    localparam int RX_IE  = 6;
    localparam int RX_ERR = 4;
    localparam int RX_FE  = 3;
    localparam int RX_PE  = 2;
    localparam int RX_OVE = 1;
    localparam int RX_CA  = 0;
    // reset values
    localparam logic [7:0] CFG_RST       = 8'h00;
    localparam logic [7:0] CFG_BOOT_RST  = 8'he2;
    localparam logic [7:0] TXCS_RST      = 8'h01;
    localparam logic [7:0] RXCS_RST      = 8'h00;
    localparam logic [7:0] RXCS_BOOT_RST = 8'h80;
    // dma channel 0 bootstrap presets
    localparam logic [15:0] DMA_MCR_BOOT  = 16'h0011;
    localparam logic [15:0] DMA_TDR_BOOT  = 16'h8100;
    localparam logic [23:0] DMA_DST_BOOT  = 24'h000000;
    localparam logic [15:0] DMA_CNT_BOOT  = 16'h0100;
    // oversampling per bit (x16 rate)
    localparam int OVS = 16;
endpackage

// *** src/ubt_rx.sv ***
`timescale 1ns/10ps
module ubt_rx
    import ubt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic       en,
    input  wire logic [1:0] bc,
    input  wire logic       par_en,
    input  wire logic       par_even,
    input  wire logic       rxd,
    output logic            done,
    output logic [7:0]      data,
    output logic            perr,
    output logic            ferr
);
    typedef enum logic [3:0] {
        R_IDLE = 4'b0001, R_START = 4'b0010, R_DATA = 4'b0100, R_EXT = 4'b1000
    } ubt_rst_t;
    typedef struct packed {
        ubt_rst_t   st;
        logic [3:0] ph;
        logic [3:0] bit_n;
        logic [8:0] sh;
        logic       done;
        logic [7:0] data;
        logic       perr;
        logic       ferr;
    } ubt_rxs_t;
    ubt_rxs_t r_ff, nxt_r;
    logic [3:0] nbits;

    // data bits plus optional parity
    assign nbits = 4'h5 + {2'b00, bc} + {3'b000, par_en};
    assign done  = r_ff.done;
    assign data  = r_ff.data;
    assign perr  = r_ff.perr;
    assign ferr  = r_ff.ferr;

    // start detect, mid-bit sampling, stop check
    always_comb begin
        nxt_r      = r_ff;
        nxt_r.done = 1'b0;
        if (tick) begin
            nxt_r.ph = r_ff.ph + 4'h1;
            unique case (r_ff.st)
                R_IDLE: begin
                    nxt_r.ph = 4'h0;
                    if (en && !rxd) nxt_r.st = R_START;
                end
                R_START: if (r_ff.ph == 4'h7) begin
                    nxt_r.ph    = 4'h0;
                    nxt_r.bit_n = 4'h0;
                    nxt_r.sh    = 9'h000;
                    nxt_r.st    = rxd ? R_IDLE : R_DATA;
                end
                R_DATA: if (r_ff.ph == 4'hf) begin
                    if (r_ff.bit_n == nbits) begin
                        nxt_r.done = 1'b1;
                        nxt_r.ferr = !rxd;
                        nxt_r.data = 8'(r_ff.sh >> (4'h9 - nbits));
                        if (par_en)
                            nxt_r.perr = (^r_ff.sh) == par_even;
                        else
                            nxt_r.perr = 1'b0;
                        nxt_r.ph = 4'h8;
                        nxt_r.st = rxd ? R_IDLE : R_EXT;
                    end else begin
                        nxt_r.sh    = {rxd, r_ff.sh[8:1]};
                        nxt_r.bit_n = r_ff.bit_n + 4'h1;
                    end
                end
                R_EXT: if (r_ff.ph == 4'hf) nxt_r.st = R_IDLE;
                default: nxt_r.st = R_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_ff <= '{st: R_IDLE, default: '0};
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end
endmodule

// *** src/ubt_tx.sv ***
`timescale 1ns/10ps
module ubt_tx
    import ubt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic [7:0] din,
    input  wire logic       force_en,
    input  wire logic       force_val,
    input  wire logic [1:0] bc,
    input  wire logic       par_en,
    input  wire logic       par_even,
    input  wire logic       two_stop,
    output logic            busy,
    output logic            txd
);
    typedef struct packed {
        logic        busy;
        logic [3:0]  ph;
        logic [3:0]  left;
        logic [11:0] sh;
        logic        txd;
    } ubt_txs_t;
    ubt_txs_t t_ff, nxt_t;
    logic [3:0] nd;
    logic [7:0] m;
    logic       pb;

    assign busy = t_ff.busy;
    assign txd  = t_ff.txd;
    assign nd   = 4'h5 + {2'b00, bc};
    assign m    = din & (8'hff >> (4'h8 - nd));
    assign pb   = (^m) ^ ~par_even;

    // frame build: start, data, parity, stops; forced frames keep length
    always_comb begin
        nxt_t = t_ff;
        if (start && !t_ff.busy) begin
            nxt_t.busy = 1'b1;
            nxt_t.ph   = 4'h0;
            nxt_t.left = nd + {3'b000, par_en} + {3'b000, two_stop} + 4'h2;
            nxt_t.sh   = (12'hfff << (nd + {3'b000, par_en} + 4'h1))
                       | ({11'h000, par_en & pb} << (nd + 4'h1))
                       | {3'h0, m, 1'b0};
            if (force_en)
                nxt_t.sh = {12{force_val}};
            nxt_t.txd = force_en ? force_val : 1'b0;
        end else if (t_ff.busy && tick) begin
            nxt_t.ph = t_ff.ph + 4'h1;
            if (t_ff.ph == 4'hf) begin
                nxt_t.left = t_ff.left - 4'h1;
                nxt_t.sh   = {force_en ? force_val : 1'b1, t_ff.sh[11:1]};
                nxt_t.txd  = t_ff.sh[1];
                if (t_ff.left == 4'h1) begin
                    nxt_t.busy = 1'b0;
                    nxt_t.txd  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            t_ff <= '{txd: 1'b1, default: '0};
        end else if (ce) begin
            t_ff <= nxt_t;
        end
    end
endmodule

// *** src/ubt_uart.sv ***
`timescale 1ns/10ps
// Operation
// - rx interrupt on char or error
// - tx interrupt when holding register empties
// - reading rx data clears char ready
// - error flags load with rx data
// - parity/overrun sticky until rx status write
// - spacing hold forces output low while tx enabled
// - dummy fill holds level one character
// - boot reset presets config e2, rx 80
// - boot presets dma channel 0 registers
// - destination starts zero, increments, 256 bytes
// - boot holds processor idle after reset
// - boot rx error drives tx low
// - after 256 bytes start fetch at 0
// - parity sense bit: clear odd, set even
// - framing error extends half bit
// - overrun when unread char replaced
module ubt_uart
    import ubt_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             bus_stall_n,
    input  wire logic             mux_bus_line_six,
    input  wire logic [DIV_W-1:0] baud_div,
    input  wire logic             rxd,
    output logic                  txd,
    output logic                  irq_tx,
    output logic                  irq_rx,
    output logic                  cpu_idle,
    output logic                  fetch_start,
    output logic                  mem_we,
    output logic [23:0]           mem_addr,
    output logic [7:0]            mem_wdata,
    output logic                  boot_mode,
    output logic [15:0]           dma_mcr,
    output logic [15:0]           dma_tdr,
    output logic [15:0]           dma_cnt
);
    typedef enum logic [2:0] {
        B_OFF = 3'b001, B_LOAD = 3'b010, B_DONE = 3'b100
    } ubt_bst_t;
    typedef struct packed {
        logic             strap_done;
        ubt_bst_t         bst;
        logic [7:0]       cfg;
        logic [7:0]       txcs;
        logic [7:0]       rxcs;
        logic [7:0]       rxdata;
        logic [7:0]       txhold;
        logic             txpend;
        logic [DIV_W-1:0] div;
        logic             tick;
        logic [2:0]       rxs;
        logic [2:0]       strap;
        logic [2:0]       warm;
        logic             rack;
        logic [31:0]      rdata;
        logic [23:0]      dst;
        logic [15:0]      cnt;
        logic             we;
        logic [7:0]       wdat;
        logic             fetch;
        logic             boot_err;
        logic             tx_was_empty;
    } ubt_st_t;
    ubt_st_t s_ff, nxt_s;
    logic       rx_done;
    logic [7:0] rx_data;
    logic       rx_perr;
    logic       rx_ferr;
    logic       tx_busy;
    logic       tx_line;
    logic       acc;
    logic       rx_in;

    // waitrequest low one cycle after a request is seen
    assign acc             = (avs_read | avs_write) & s_ff.rack;
    assign avs_waitrequest = (avs_read | avs_write) & ~s_ff.rack;
    assign avs_readdata    = s_ff.rdata;
    // synchronised serial input (third stage taken as is)
    assign rx_in = (s_ff.rxs[2] == s_ff.rxs[1]) ? s_ff.rxs[1] : s_ff.rxs[2];

    ubt_rx u_rx (
        .clk      (clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .tick     (s_ff.tick),
        .en       (s_ff.rxcs[RX_EN]),
        .bc       (s_ff.cfg[CFG_BC_LSB+1:CFG_BC_LSB]),
        .par_en   (s_ff.cfg[CFG_PAR]),
        .par_even (s_ff.cfg[CFG_EO]),
        .rxd      (rx_in),
        .done     (rx_done),
        .data     (rx_data),
        .perr     (rx_perr),
        .ferr     (rx_ferr)
    );

    ubt_tx u_tx (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .tick      (s_ff.tick),
        .start     (s_ff.txpend & s_ff.txcs[TX_EN]),
        .din       (s_ff.txhold),
        .force_en  (s_ff.txcs[TX_FRC]),
        .force_val (s_ff.txcs[TX_VAL]),
        .bc        (s_ff.cfg[CFG_BC_LSB+1:CFG_BC_LSB]),
        .par_en    (s_ff.cfg[CFG_PAR]),
        .par_even  (s_ff.cfg[CFG_EO]),
        .two_stop  (s_ff.txcs[TX_SB]),
        .busy      (tx_busy),
        .txd       (tx_line)
    );

    // output line: disabled and idle marks, hold forces space when enabled, boot error low
    always_comb begin
        if (s_ff.boot_err)
            txd = 1'b0;
        else if (!s_ff.txcs[TX_EN] && !tx_busy)
            txd = 1'b1;
        else if (s_ff.txcs[TX_BRK] && s_ff.txcs[TX_EN])
            txd = 1'b0;
        else
            txd = tx_line;
    end

    assign irq_tx      = s_ff.txcs[TX_IE] & s_ff.txcs[TX_BE];
    assign irq_rx      = s_ff.rxcs[RX_IE] & (s_ff.rxcs[RX_CA] | s_ff.rxcs[RX_ERR]);
    assign cpu_idle    = s_ff.bst != B_OFF && s_ff.bst != B_DONE || !s_ff.strap_done;
    assign fetch_start = s_ff.fetch;
    assign mem_we      = s_ff.we;
    assign mem_addr    = s_ff.dst;
    assign mem_wdata   = s_ff.wdat;
    assign boot_mode   = s_ff.bst != B_OFF;
    assign dma_mcr     = boot_mode ? DMA_MCR_BOOT : 16'h0000;
    assign dma_tdr     = boot_mode ? DMA_TDR_BOOT : 16'h0000;
    assign dma_cnt     = s_ff.cnt;

    // main next-state
    always_comb begin
        logic       rd_data;
        logic       wr_rxcs;
        logic       dma_take;
        logic       new_ove;
        rd_data  = 1'b0;
        wr_rxcs  = 1'b0;
        dma_take = 1'b0;
        new_ove  = 1'b0;
        nxt_s       = s_ff;
        nxt_s.we    = 1'b0;
        nxt_s.fetch = 1'b0;
        nxt_s.rack  = (avs_read | avs_write) & ~s_ff.rack;
        nxt_s.rxs   = {s_ff.rxs[1:0], rxd};
        nxt_s.strap = {s_ff.strap[1:0], ~bus_stall_n & mux_bus_line_six};
        nxt_s.warm  = {s_ff.warm[1:0], 1'b1};
        // oversampling (x16 bit-rate) tick generator
        if (s_ff.div == '0) begin
            nxt_s.div  = baud_div;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.div  = s_ff.div - 1'b1;
            nxt_s.tick = 1'b0;
        end
        // strap judged once all three flops hold post-release samples
        if (!s_ff.strap_done && s_ff.warm[2]) begin
            nxt_s.strap_done = 1'b1;
            if (s_ff.strap[2] && s_ff.strap[1]) begin
                nxt_s.bst  = B_LOAD;
                nxt_s.cfg  = CFG_BOOT_RST;
                nxt_s.rxcs = RXCS_BOOT_RST;
                nxt_s.dst  = DMA_DST_BOOT;
                nxt_s.cnt  = DMA_CNT_BOOT;
            end
        end
        // register reads captured in the wait cycle, standing at acceptance
        if (avs_read && !s_ff.rack) begin
            unique case (avs_address)
                ADDR_CFG:    nxt_s.rdata = {24'h0, s_ff.cfg};
                ADDR_TXCS:   nxt_s.rdata = {24'h0, s_ff.txcs};
                ADDR_RXCS:   nxt_s.rdata = {24'h0, s_ff.rxcs};
                ADDR_RXDATA: begin
                    nxt_s.rdata = {24'h0, s_ff.rxdata};
                    rd_data     = 1'b1;
                end
                ADDR_BOOT:   nxt_s.rdata = {29'h0, s_ff.bst};
                default:     nxt_s.rdata = 32'h0;
            endcase
        end
        // register writes
        if (acc && avs_write) begin
            unique case (avs_address)
                ADDR_CFG:    nxt_s.cfg = avs_writedata[7:0];
                ADDR_TXCS:   nxt_s.txcs[7:1] = {avs_writedata[7:6], 1'b0,
                                                avs_writedata[4:1]};
                ADDR_RXCS: begin
                    nxt_s.rxcs[7:6] = avs_writedata[7:6];
                    wr_rxcs         = 1'b1;
                end
                ADDR_TXDATA: begin
                    nxt_s.txhold       = avs_writedata[7:0];
                    nxt_s.txpend       = 1'b1;
                    nxt_s.txcs[TX_BE]  = 1'b0;
                end
                default: ;
            endcase
        end
        // holding register moves into the shifter
        if (s_ff.txpend && s_ff.txcs[TX_EN] && !tx_busy) begin
            nxt_s.txpend      = 1'b0;
            nxt_s.txcs[TX_BE] = 1'b1;
        end
        // bootstrap dma channel 0 takes each ready character until a boot rx error is flagged
        if (s_ff.bst == B_LOAD && s_ff.rxcs[RX_CA] && !s_ff.boot_err) begin
            dma_take    = 1'b1;
            nxt_s.we    = 1'b1;
            nxt_s.wdat  = s_ff.rxdata;
            nxt_s.cnt   = s_ff.cnt - 16'h1;
        end
        // address steps and fetch starts only after the store is shown
        if (s_ff.we) begin
            nxt_s.dst = s_ff.dst + 24'h1;
            if (s_ff.cnt == 16'h0) begin
                nxt_s.bst   = B_DONE;
                nxt_s.fetch = 1'b1;
            end
        end
        // character ready clears on read, sticky flags clear on write
        if (rd_data || dma_take)
            nxt_s.rxcs[RX_CA] = 1'b0;
        if (wr_rxcs) begin
            nxt_s.rxcs[RX_PE]  = 1'b0;
            nxt_s.rxcs[RX_OVE] = 1'b0;
        end
        // new character: load data and errors together, set beats clear
        if (rx_done) begin
            new_ove             = s_ff.rxcs[RX_CA] && !(rd_data || dma_take);
            nxt_s.rxdata        = rx_data;
            nxt_s.rxcs[RX_CA]   = 1'b1;
            nxt_s.rxcs[RX_FE]   = rx_ferr;
            if (rx_perr)
                nxt_s.rxcs[RX_PE] = 1'b1;
            if (new_ove)
                nxt_s.rxcs[RX_OVE] = 1'b1;
            if (s_ff.bst == B_LOAD && (rx_perr || rx_ferr || new_ove))
                nxt_s.boot_err = 1'b1;
        end
        nxt_s.rxcs[RX_ERR] = nxt_s.rxcs[RX_FE] | nxt_s.rxcs[RX_PE] | nxt_s.rxcs[RX_OVE];
        nxt_s.rxcs[5]      = 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '{bst: B_OFF, cfg: CFG_RST, txcs: TXCS_RST, rxcs: RXCS_RST,
                      rxs: 3'b111, default: '0};
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end
endmodule
